// ### core/spf_pkg.sv
// Constants and types for the SPI FIFO, DMA-request and low-power block.
// Assumes one system clock plus the slave serial clock as a second domain.
// How it works
// - Separate receive and transmit FIFOs, eight elements of sixteen bits each.
// - Frame width four to sixteen bits; each frame takes one FIFO element.
// - With frames of eight bits or fewer, FIFO capacity may double to sixteen.
// - Receive-not-empty and transmit-not-full events; flags stick until software clears.
// - Light sleep changes nothing; slave traffic still raises its events.
// - Deep-sleep wake comes only from slave mode with wake enabled.
// - Entering deep sleep flushes both FIFOs in either mode.
// - Master disable aborts the frame at once, not at a boundary.
// - Slave releases MISO on disable, or on deep-sleep entry when wake disabled.
// - Master done needs empty transmit FIFO, empty shifter and select released.
// - Slave in deep sleep with wake enabled wakes on select and answers with all-ones data.
// - Master normally samples MISO half an SCLK period after driving.
// - Late sampling moves master capture half a period later, alternate edge.
// - Receive DMA request holds while receive count exceeds receive level.
// - Transmit DMA request holds while transmit count is below transmit level.
// - A DMA request drops within four system clocks once its condition ends.
// - Continuous mode keeps select across frames; separated mode drops it between.
package spf_pkg;
  localparam int DATA_W = 16;
  localparam int DEPTH = 8;
  localparam int DEPTH_DBL = 16;
  localparam int CNT_W = 5;
  localparam int WID_W = 5;
  localparam logic [4:0] WID_DBL_MAX = 5'h08;
  localparam int DMA_CLR_CYC = 4;
  localparam int HALF_DIV = 2;
  localparam logic [15:0] NACK_WORD = 16'hFFFF;
  localparam int FLG_RXNE = 0;
  localparam int FLG_TXNF = 1;
  localparam int FLG_DONE = 2;
  localparam int FLG_WAKE = 3;
  localparam int NFLG = 4;
  typedef enum logic [2:0] {SPF_IDLE, SPF_LEAD, SPF_SHIFT, SPF_TRAIL, SPF_GAP} spf_state_e;
endpackage

// ### core/spf_fifo_if.sv
// FIFO port bundle between the controller and its FIFOs.
// Assumes both sides run on the system clock.
`timescale 1ns/1ps
interface spf_fifo_if;
  logic wr_valid;
  logic wr_ready;
  logic [15:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [15:0] rd_data;
  logic [4:0] count;
  logic flush;
  logic dbl;
  modport store (input wr_valid, wr_data, rd_ready, flush, dbl,
    output wr_ready, rd_valid, rd_data, count);
  modport user (output wr_valid, wr_data, rd_ready, flush, dbl,
    input wr_ready, rd_valid, rd_data, count);
endinterface

// ### core/spf_fifo.sv
// One sixteen-bit FIFO, eight deep or sixteen deep when doubled.
// Assumes depth mode changes only while the FIFO is empty.
`timescale 1ns/1ps
module spf_fifo
(
  input wire logic clock,
  input wire logic reset_n,
  spf_fifo_if.store f
);
  logic [15:0] mem_q [spf_pkg::DEPTH_DBL];
  logic [3:0] wp_q, wp_d, rp_q, rp_d;
  logic [4:0] cnt_q, cnt_d, cap;
  logic push, pop;

  always_comb
  begin
    cap = f.dbl ? 5'(spf_pkg::DEPTH_DBL) : 5'(spf_pkg::DEPTH);
    push = f.wr_valid && f.wr_ready;
    pop = f.rd_valid && f.rd_ready;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (f.flush)
    begin
      wp_d = 4'h0;
      rp_d = 4'h0;
      cnt_d = 5'h00;
    end
    else
    begin
      if (push)
        wp_d = ({1'b0, wp_q} + 5'h01 == cap) ? 4'h0 : wp_q + 4'h1;
      if (pop)
        rp_d = ({1'b0, rp_q} + 5'h01 == cap) ? 4'h0 : rp_q + 4'h1;
      cnt_d = cnt_q + {4'h0, push} - {4'h0, pop};
    end
  end

  assign f.wr_ready = (cnt_q < cap) && !f.flush;
  assign f.rd_valid = cnt_q != 5'h00;
  assign f.rd_data = mem_q[rp_q];
  assign f.count = cnt_q;

  // Storage has no reset; only pointers and count carry state
  always_ff @(posedge clock)
    if (push && !f.flush)
      mem_q[wp_q] <= f.wr_data;

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      cnt_q <= 5'h00;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
endmodule // spf_fifo

// ### core/spf_link.sv
// Slave shifter clocked by the external serial clock, SPI mode 0.
// Assumes select frames the clock; tx_word and width are held stable.
`timescale 1ns/1ps
module spf_link
(
  input wire logic link_clock,
  input wire logic reset_n,
  input wire logic ss_active,
  input wire logic mosi,
  input wire logic [4:0] width,
  input wire logic nack,
  input wire logic [15:0] tx_word,
  output logic miso_bit,
  output logic [15:0] rx_word,
  output logic rx_toggle,
  output logic load_toggle
);
  logic frame_rst_n, nack_s1_q, nack_q;
  logic [4:0] bit_q, bit_d;
  logic [15:0] sh_q, sh_d, cur_q, cur_d, rxw_d, src;
  logic rxt_d, ldt_d, miso_q, miso_d;

  // Deselect clears the frame so a broken frame never leaks into the next
  assign frame_rst_n = reset_n && ss_active;
  // Link clock idles between frames, so the synced flag is stale at bit 0;
  // the all-ones word comes in on tx_word and the flag only gates receive
  assign src = tx_word;

  always_comb
  begin
    sh_d = {sh_q[14:0], mosi};
    bit_d = bit_q + 5'h01;
    rxw_d = rx_word;
    rxt_d = rx_toggle;
    cur_d = (bit_q == 5'h00) ? src : cur_q;
    ldt_d = (bit_q == 5'h00) ? !load_toggle : load_toggle;
    if (bit_d == width)
    begin
      bit_d = 5'h00;
      rxw_d = sh_d;
      rxt_d = rx_toggle ^ !nack_q;
    end
    // Next bit out is number bit_q; bit_d may already have wrapped
    miso_d = cur_d[4'(width - bit_q - 5'h01)];
  end

  always_ff @(posedge link_clock or negedge reset_n)
    if (!reset_n)
    begin
      nack_s1_q <= 1'b0;
      nack_q <= 1'b0;
      rx_word <= 16'h0000;
      rx_toggle <= 1'b0;
      load_toggle <= 1'b0;
    end
    else
    begin
      nack_s1_q <= nack;
      nack_q <= nack_s1_q;
      rx_word <= rxw_d;
      rx_toggle <= ss_active ? rxt_d : rx_toggle;
      load_toggle <= ss_active ? ldt_d : load_toggle;
    end

  always_ff @(posedge link_clock or negedge frame_rst_n)
    if (!frame_rst_n)
    begin
      bit_q <= 5'h00;
      sh_q <= 16'h0000;
      cur_q <= 16'h0000;
    end
    else
    begin
      bit_q <= bit_d;
      sh_q <= sh_d;
      cur_q <= cur_d;
    end

  // Mode 0: drive on the falling edge
  always_ff @(negedge link_clock or negedge frame_rst_n)
    if (!frame_rst_n)
      miso_q <= 1'b0;
    else
      miso_q <= miso_d;

  assign miso_bit = (bit_q == 5'h00) ? src[4'(width - 5'h01)] : miso_q;
endmodule // spf_link

// ### core/spf_top.sv
// SPI FIFO, DMA-request and low-power controller, master or slave.
// Assumes system clock at 40 MHz; slave serial clock is link_clock.
`timescale 1ns/1ps
module spf_top
#(
  parameter int HALF_DIV = spf_pkg::HALF_DIV
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic link_clock,
  input wire logic enable,
  input wire logic master_mode,
  input wire logic late_sample,
  input wire logic continuous,
  input wire logic [4:0] width,
  input wire logic double_en,
  input wire logic wake_en,
  input wire logic deep_sleep,
  input wire logic [4:0] rx_level,
  input wire logic [4:0] tx_level,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [15:0] tx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [15:0] rx_data,
  output logic [4:0] rx_count,
  output logic [4:0] tx_count,
  input wire logic [3:0] flag_clear,
  output logic [3:0] flags,
  output logic busy,
  output logic wake_request,
  output logic rx_dma_request,
  output logic tx_dma_request,
  output logic sclk_out,
  output logic sclk_oe,
  output logic ss_out_n,
  output logic ss_oe,
  input wire logic ss_in_n,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic miso_in
);
  localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

  spf_fifo_if txf ();
  spf_fifo_if rxf ();

  spf_fifo u_tx_fifo
  (
    .clock(clock),
    .reset_n(reset_n),
    .f(txf.store)
  );

  spf_fifo u_rx_fifo
  (
    .clock(clock),
    .reset_n(reset_n),
    .f(rxf.store)
  );

  // Synchronisers: 0 miso, 1 select, 2 rx toggle, 3 load toggle
  logic [3:0] s1_q, s2_q, s3_q, sync_in;
  logic l_miso, l_rxtog, l_ldtog;
  logic [15:0] l_rxword;

  assign sync_in = {l_ldtog, l_rxtog, !ss_in_n, miso_in};

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end
    else
    begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end

  logic miso_s, ss_s, rx_ev, ld_ev, slave, mact, dbl_eff;
  assign miso_s = s2_q[0];
  assign ss_s = s2_q[1];
  assign rx_ev = s2_q[2] ^ s3_q[2];
  assign ld_ev = s2_q[3] ^ s3_q[3];
  assign slave = enable && !master_mode;
  assign mact = enable && master_mode;
  assign dbl_eff = double_en && (width <= spf_pkg::WID_DBL_MAX);

  // Master engine
  spf_pkg::spf_state_e st_q, st_d;
  logic [7:0] div_q, div_d;
  logic [4:0] half_q, half_d;
  logic [15:0] sh_q, sh_d, rsh_q, rsh_d;
  logic sclk_q, sclk_d, ss_q, ss_d, mosi_q, mosi_d;
  logic m_pop, m_push, m_done, tick, last_edge;

  assign tick = div_q == DIV_LAST;
  assign last_edge = half_q == 5'(width + width - 5'h01);

  always_comb
  begin
    st_d = st_q;
    div_d = tick ? 8'h00 : div_q + 8'h01;
    half_d = half_q;
    sh_d = sh_q;
    rsh_d = rsh_q;
    sclk_d = sclk_q;
    ss_d = ss_q;
    mosi_d = mosi_q;
    m_pop = 1'b0;
    m_push = 1'b0;
    m_done = 1'b0;
    case (st_q)
      spf_pkg::SPF_IDLE:
      begin
        div_d = 8'h00;
        if (mact && txf.rd_valid)
        begin
          m_pop = 1'b1;
          sh_d = txf.rd_data;
          mosi_d = txf.rd_data[4'(width - 5'h01)];
          ss_d = 1'b1;
          rsh_d = 16'h0000;
          st_d = spf_pkg::SPF_LEAD;
        end
      end
      spf_pkg::SPF_LEAD:
        if (tick)
        begin
          half_d = 5'h00;
          st_d = spf_pkg::SPF_SHIFT;
        end
      spf_pkg::SPF_SHIFT:
        if (tick)
        begin
          sclk_d = !sclk_q;
          half_d = half_q + 5'h01;
          if (half_q[0] == late_sample)
            rsh_d = {rsh_q[14:0], miso_s};
          if (half_q[0] && !last_edge)
          begin
            sh_d = {sh_q[14:0], 1'b0};
            mosi_d = sh_q[4'(width - 5'h02)];
          end
          if (last_edge)
          begin
            m_push = 1'b1;
            st_d = spf_pkg::SPF_TRAIL;
          end
        end
      spf_pkg::SPF_TRAIL:
        if (tick)
        begin
          if (continuous && txf.rd_valid)
          begin
            m_pop = 1'b1;
            sh_d = txf.rd_data;
            mosi_d = txf.rd_data[4'(width - 5'h01)];
            half_d = 5'h00;
            rsh_d = 16'h0000;
            st_d = spf_pkg::SPF_SHIFT;
          end
          else
          begin
            ss_d = 1'b0;
            st_d = spf_pkg::SPF_GAP;
          end
        end
      spf_pkg::SPF_GAP:
        if (tick)
        begin
          m_done = !txf.rd_valid;
          st_d = spf_pkg::SPF_IDLE;
        end
      default:
        st_d = spf_pkg::SPF_IDLE;
    endcase
    if (!mact)
    begin
      st_d = spf_pkg::SPF_IDLE;
      ss_d = 1'b0;
      sclk_d = 1'b0;
      m_pop = 1'b0;
      m_push = 1'b0;
      m_done = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      st_q <= spf_pkg::SPF_IDLE;
      div_q <= 8'h00;
      half_q <= 5'h00;
      sh_q <= 16'h0000;
      rsh_q <= 16'h0000;
      sclk_q <= 1'b0;
      ss_q <= 1'b0;
      mosi_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      div_q <= div_d;
      half_q <= half_d;
      sh_q <= sh_d;
      rsh_q <= rsh_d;
      sclk_q <= sclk_d;
      ss_q <= ss_d;
      mosi_q <= mosi_d;
    end

  // Slave side and low power
  logic [15:0] stx_q, stx_d;
  logic stx_full_q, stx_full_d, ds_prev_q, hold_q, hold_d;
  logic drive_q, drive_d, nack_q, nack_d, wake_q, wake_d;
  logic enter_ds, s_pop, s_push;

  assign enter_ds = deep_sleep && !ds_prev_q;
  // Slave prefetches one word so the link never waits on the FIFO
  assign s_pop = slave && !stx_full_q && txf.rd_valid && !enter_ds;
  assign s_push = slave && rx_ev && !nack_q;

  always_comb
  begin
    stx_d = stx_q;
    stx_full_d = stx_full_q;
    if (ld_ev)
      stx_full_d = 1'b0;
    if (s_pop)
    begin
      stx_d = txf.rd_data;
      stx_full_d = 1'b1;
    end
    if (enter_ds || !slave)
      stx_full_d = 1'b0;
    hold_d = hold_q;
    if (!ss_s)
      hold_d = 1'b0;
    if (enter_ds && ss_s)
      hold_d = 1'b1;
    drive_d = slave && !hold_d && (wake_en || !deep_sleep);
    nack_d = slave && wake_en && deep_sleep;
    // All ones ride on the word itself; the link cannot sync while idle
    if (nack_d)
      stx_d = spf_pkg::NACK_WORD;
    wake_d = nack_d && ss_s;
  end

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      stx_q <= 16'h0000;
      stx_full_q <= 1'b0;
      ds_prev_q <= 1'b0;
      hold_q <= 1'b0;
      drive_q <= 1'b0;
      nack_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      stx_q <= stx_d;
      stx_full_q <= stx_full_d;
      ds_prev_q <= deep_sleep;
      hold_q <= hold_d;
      drive_q <= drive_d;
      nack_q <= nack_d;
      wake_q <= wake_d;
    end

  spf_link u_link
  (
    .link_clock(link_clock),
    .reset_n(reset_n),
    .ss_active(!ss_in_n),
    .mosi(mosi_in),
    .width(width),
    .nack(nack_q),
    .tx_word(stx_q),
    .miso_bit(l_miso),
    .rx_word(l_rxword),
    .rx_toggle(l_rxtog),
    .load_toggle(l_ldtog)
  );

  // FIFO hookup; overrun frames are dropped when the receive FIFO is full
  assign txf.wr_valid = tx_valid;
  assign txf.wr_data = tx_data;
  assign txf.rd_ready = m_pop || s_pop;
  assign txf.flush = enter_ds;
  assign txf.dbl = dbl_eff;
  assign rxf.wr_valid = m_push || s_push;
  assign rxf.wr_data = master_mode ? rsh_d : l_rxword;
  assign rxf.rd_ready = rx_ready;
  assign rxf.flush = enter_ds;
  assign rxf.dbl = dbl_eff;
  assign tx_ready = txf.wr_ready;
  assign rx_valid = rxf.rd_valid;
  assign rx_data = rxf.rd_data;
  assign rx_count = rxf.count;
  assign tx_count = txf.count;

  // Event flags and DMA requests
  logic [3:0] flg_q, flg_d, flg_set;
  logic rxd_q, rxd_d, txd_q, txd_d;

  always_comb
  begin
    flg_set = 4'h0;
    flg_set[spf_pkg::FLG_RXNE] = rxf.rd_valid;
    flg_set[spf_pkg::FLG_TXNF] = txf.wr_ready;
    flg_set[spf_pkg::FLG_DONE] = m_done;
    flg_set[spf_pkg::FLG_WAKE] = wake_q;
    // Set beats clear so no event is lost
    flg_d = (flg_q & ~flag_clear) | flg_set;
    rxd_d = rxf.count > rx_level;
    txd_d = txf.count < tx_level;
  end

  // One register stage: requests fall one clock after the condition ends
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      flg_q <= 4'h0;
      rxd_q <= 1'b0;
      txd_q <= 1'b0;
    end
    else
    begin
      flg_q <= flg_d;
      rxd_q <= rxd_d;
      txd_q <= txd_d;
    end

  assign flags = flg_q;
  assign rx_dma_request = rxd_q;
  assign tx_dma_request = txd_q;
  assign busy = st_q != spf_pkg::SPF_IDLE;
  assign wake_request = wake_q;
  assign sclk_out = sclk_q;
  assign ss_out_n = !ss_q;
  assign mosi_out = mosi_q;
  assign sclk_oe = mact;
  assign ss_oe = mact;
  assign mosi_oe = mact;
  assign miso_out = l_miso;
  // Pad enable follows select directly; no data path through it
  assign miso_oe = drive_q && !ss_in_n;
endmodule // spf_top

// ### bench/spf_assertions.sv
// Checker for spf_top, bound to every instance of it.
// Assumes all watched ports belong to the system clock domain.
`timescale 1ns/1ps
module spf_assertions
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic master_mode,
  input wire logic double_en,
  input wire logic wake_en,
  input wire logic deep_sleep,
  input wire logic ss_in_n,
  input wire logic [4:0] rx_level,
  input wire logic [4:0] tx_level,
  input wire logic [4:0] rx_count,
  input wire logic [4:0] tx_count,
  input wire logic tx_ready,
  input wire logic [3:0] flag_clear,
  input wire logic [3:0] flags,
  input wire logic wake_request,
  input wire logic rx_dma_request,
  input wire logic tx_dma_request,
  input wire logic sclk_out,
  input wire logic ss_out_n,
  input wire logic miso_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_full_refused: assert property (!double_en && tx_count == 5'h08 |-> !tx_ready)
    else $error("tx push open while full");
  a_depth_cap: assert property (!double_en |-> tx_count <= 5'h08 && rx_count <= 5'h08)
    else $error("fifo count above depth");
  a_rx_dma_set: assert property ((rx_count > rx_level) [*2] |-> rx_dma_request)
    else $error("rx dma request missing");
  a_tx_dma_set: assert property ((tx_count < tx_level) [*2] |-> tx_dma_request)
    else $error("tx dma request missing");
  a_rx_dma_clear: assert property ((rx_count <= rx_level) [*4] |-> !rx_dma_request)
    else $error("rx dma request late to drop");
  a_tx_dma_clear: assert property ((tx_count >= tx_level) [*4] |-> !tx_dma_request)
    else $error("tx dma request late to drop");
  a_flush_entry: assert property ($rose(deep_sleep) |=> tx_count == 5'h00 && rx_count == 5'h00)
    else $error("fifo kept data in deep sleep");
  a_master_no_wake: assert property ((master_mode || !wake_en || !deep_sleep) [*2] |-> !wake_request)
    else $error("wake without slave wake setup");
  a_slave_wakes: assert property ((deep_sleep && wake_en && !master_mode && !ss_in_n) [*4]
    |-> wake_request)
    else $error("no wake on select");
  a_flag_sticky: assert property (flags[2] && !flag_clear[2] |=> flags[2])
    else $error("flag lost without clear");
  a_done_idle: assert property ($rose(flags[2]) |-> ss_out_n && tx_count == 5'h00)
    else $error("done before select released");
  a_abort_now: assert property (master_mode && $fell(enable) |=> ss_out_n && !sclk_out)
    else $error("frame not aborted");
  a_slave_release: assert property ((!master_mode && !enable) [*2] |-> !miso_oe)
    else $error("miso driven while disabled");
endmodule // spf_assertions

bind spf_top spf_assertions spf_assertions_i (.*);

// ### bench/spf_slave_model.sv
// External slave device in SPI mode 0 facing the master pins.
// Assumes width is held stable while select is low.
`timescale 1ns/1ps
module spf_slave_model
(
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic [4:0] width,
  input wire logic [15:0] word,
  output logic miso,
  output logic [15:0] got
);
  logic [4:0] idx = 5'h00;
  // Released line shows the inverse so a stale bit never passes
  assign miso = ss_n ? ~word[idx] : word[idx];
  always @(negedge ss_n) idx = width - 5'h01;
  // Wraps so back-to-back frames under one select still line up
  always @(negedge sclk) idx = (idx == 5'h00) ? width - 5'h01 : idx - 5'h01;
  always @(posedge sclk) if (!ss_n) got = {got[14:0], mosi};
endmodule // spf_slave_model

// ### bench/tb_top.sv
// Bench for spf_top: FIFO, DMA, master, slave and sleep tests.
// Assumes the slave model on the master pins; link clock made here.
`timescale 1ns/1ps
module tb_top;
  logic clock, reset_n, link_clock, enable, master_mode, late_sample, continuous;
  logic double_en, wake_en, deep_sleep, tx_valid, rx_ready, ss_in_n, mosi_in, miso_in;
  logic tx_ready, rx_valid, busy, wake_request, rx_dma_request, tx_dma_request, wk;
  logic sclk_out, sclk_oe, ss_out_n, ss_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic [4:0] width, rx_level, tx_level, rx_count, tx_count;
  logic [3:0] flag_clear, flags;
  logic [15:0] tx_data, rx_data, got, sword;
  logic [7:0] mi;
  int n_mismatch, checked, rises, i, j, k;
  // Slower serial clock leaves the two-flop miso sync enough margin
  spf_top #(.HALF_DIV(4)) spf_top_i (.*);
  spf_slave_model spf_slave_model_i (.sclk(sclk_out), .ss_n(ss_out_n), .mosi(mosi_out),
    .width(width), .word(sword), .miso(miso_in), .got(got));
  initial
  begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge ss_out_n) rises++;
  task automatic cmp_bit(string nm, logic e, logic g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic cmp_word(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic push(logic [15:0] d);
    @(negedge clock);
    tx_valid = 1;
    tx_data = d;
    @(negedge clock);
    tx_valid = 0;
  endtask
  task automatic pop(logic [15:0] e);
    @(negedge clock);
    cmp_bit("rx_valid", 1'b1, rx_valid);
    cmp_word("rx_data", e, rx_data);
    rx_ready = 1;
    @(negedge clock);
    rx_ready = 0;
  endtask
  task automatic sleep();
    @(negedge clock);
    deep_sleep = 1;
    repeat (2) @(negedge clock);
    deep_sleep = 0;
    @(negedge clock);
  endtask
  task automatic pulse_clear(logic [3:0] m);
    flag_clear = m;
    @(negedge clock);
    flag_clear = 4'h0;
  endtask
  // Link clock runs only inside the frame, off the system clock phase
  task automatic sframe(logic [7:0] mo);
    @(negedge clock);
    ss_in_n = 0;
    repeat (6) @(negedge clock);
    wk = wake_request;
    cmp_bit("miso_oe", 1'b1, miso_oe);
    #7;
    for (i = 7; i >= 0; i--)
    begin
      mosi_in = mo[i];
      #24;
      mi[i] = miso_out;
      link_clock = 1;
      #24 link_clock = 0;
    end
    mosi_in = ~mo[0];
    @(negedge clock);
    ss_in_n = 1;
  endtask
  initial
  begin
    {enable, late_sample, continuous, double_en, wake_en, deep_sleep} = 6'h00;
    {tx_valid, rx_ready, link_clock, mosi_in, wk} = 5'h00;
    master_mode = 1;
    ss_in_n = 1;
    width = 5'h08;
    rx_level = 5'h00;
    tx_level = 5'h02;
    flag_clear = 4'h0;
    tx_data = 16'h0000;
    mi = 8'h00;
    sword = 16'h00A5;
    n_mismatch = 0;
    checked = 0;
    reset_n = 0;
    repeat (2) @(negedge clock);
    reset_n = 1;
    repeat (2) @(negedge clock);
    cmp_bit("tx_ready", 1'b1, tx_ready);
    cmp_bit("tx_dma_request", 1'b1, tx_dma_request);
    for (j = 0; j < 8; j++) push(16'h1110 | 16'(j));
    @(negedge clock);
    cmp_word("tx_count", 16'h0008, {11'h000, tx_count});
    cmp_bit("tx_ready", 1'b0, tx_ready);
    cmp_bit("tx_dma_request", 1'b0, tx_dma_request);
    pulse_clear(4'h2);
    @(negedge clock);
    cmp_bit("txnf_flag", 1'b0, flags[1]);
    sleep();
    cmp_word("tx_count", 16'h0000, {11'h000, tx_count});
    double_en = 1;
    for (j = 0; j < 9; j++) push(16'h0020 | 16'(j));
    @(negedge clock);
    cmp_word("tx_count", 16'h0009, {11'h000, tx_count});
    sleep();
    double_en = 0;
    $display("test fifo done");
    enable = 1;
    for (j = 0; j < 2; j++)
    begin
      late_sample = j[0];
      continuous = j[0];
      rises = 0;
      push(16'h013C);
      push(16'h0081);
      for (k = 0; k < 3000 && flags[2] !== 1'b1; k++) @(negedge clock);
      if (k == 3000)
      begin
        n_mismatch++;
        final_report();
      end
      pulse_clear(4'h4);
      cmp_word("select_rises", 16'(2 - j), 16'(rises));
      cmp_word("mosi_word", 16'h0081, {8'h00, got[7:0]});
      cmp_bit("rx_dma_request", 1'b1, rx_dma_request);
      cmp_word("rx_count", 16'h0002, {11'h000, rx_count});
      cmp_bit("rxne_flag", 1'b1, flags[0]);
      cmp_bit("master_oe", 1'b1, sclk_oe & ss_oe & mosi_oe);
      pop(16'h00A5);
      pop(16'h00A5);
      repeat (4) @(negedge clock);
      cmp_bit("rx_dma_request", 1'b0, rx_dma_request);
      $display("test master %0d done", j);
    end
    push(16'h00FF);
    repeat (20) @(negedge clock);
    enable = 0;
    repeat (2) @(negedge clock);
    cmp_bit("ss_out_n", 1'b1, ss_out_n);
    cmp_bit("busy", 1'b0, busy);
    cmp_bit("master_oe", 1'b0, sclk_oe | ss_oe | mosi_oe);
    sleep();
    master_mode = 0;
    enable = 1;
    push(16'h00C3);
    sframe(8'h5A);
    cmp_word("miso_word", 16'h00C3, {8'h00, mi});
    repeat (6) @(negedge clock);
    pop(16'h005A);
    wake_en = 1;
    deep_sleep = 1;
    sframe(8'h33);
    cmp_bit("wake_request", 1'b1, wk);
    cmp_word("miso_word", 16'h00FF, {8'h00, mi});
    cmp_bit("wake_flag", 1'b1, flags[3]);
    deep_sleep = 0;
    repeat (20) @(negedge clock);
    push(16'h0096);
    sframe(8'h33);
    cmp_word("miso_word", 16'h0096, {8'h00, mi});
    repeat (6) @(negedge clock);
    pop(16'h0033);
    wake_en = 0;
    enable = 0;
    ss_in_n = 0;
    repeat (3) @(negedge clock);
    cmp_bit("miso_oe", 1'b0, miso_oe);
    ss_in_n = 1;
    $display("test slave done");
    final_report();
  end
endmodule // tb_top
